// [rtl/csr_cfg.svh]
/*
 * constants for the core status and control register block: register offsets,
 * flag bit positions, reset values.
 * assumes inclusion by bare name from rtl/.
 */
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// register offsets on the plain register port
`define CSR_OFF_FLAGS 4'h0
`define CSR_OFF_IPTR 4'h1
`define CSR_OFF_FADDR 4'h2
`define CSR_OFF_PDBR 4'h3
`define CSR_OFF_MODE 4'h4
`define CSR_OFF_CTX 4'h5
`define CSR_OFF_STAT 4'h6

// status flag and mode register bit positions
`define CSR_B_CF 0
`define CSR_B_PF 2
`define CSR_B_AF 4
`define CSR_B_ZF 6
`define CSR_B_SF 7
`define CSR_B_TF 8
`define CSR_B_IF 9
`define CSR_B_DF 10
`define CSR_B_OF 11
`define CSR_B_IO_PRIVILEGE_LEVEL_LO 12
`define CSR_B_IO_PRIVILEGE_LEVEL_HI 13
`define CSR_B_NT 14
`define CSR_B_RF 16
`define CSR_B_VM 17
`define CSR_B_AC 18
`define CSR_B_AM 18
`define CSR_B_PE 0
`define CSR_B_PG 31

// writable flag mask, reserved bit 1 reads as one
`define CSR_FLAGS_WMASK 32'h0007_7FD5
`define CSR_FLAGS_FIXED1 32'h0000_0002

// reset values
`define CSR_RST_FLAGS 32'h0000_0002
`define CSR_RST_IPTR 32'h0000_0000
`define CSR_RST_MODE 32'h0000_0010
`define CSR_RST_ZERO 32'h0000_0000

// page directory base keeps its low 12 bits zero
`define CSR_PDBR_MASK 32'hFFFF_F000

`endif

// [rtl/csr_pkg.sv]
/*
 * types for the core status and control register block.
 * assumes csr_cfg.svh provides the numeric constants.
 */
package csr_pkg;

    // which flag groups the retiring instruction defines
    typedef struct packed {
        logic arith;    // carry, aux, overflow from the adder
        logic logic_op; // parity, zero, sign only; carry and overflow cleared
        logic keep_cf;  // arith but carry left alone
    } csr_fupd_t;

    // retirement of one instruction from the execute stage
    typedef struct packed {
        logic valid;
        logic [31:0] next_ip;
        logic jump;
        logic [31:0] jump_ip;
        logic sub;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] res;
        csr_fupd_t fupd;
        logic popf;
        logic [31:0] pop_val;
        logic pop_16;
        logic iret;
        logic task_sw;
    } csr_retire_t;

    // register-port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } csr_bus_t;

    // policy decisions that the core consumes
    typedef struct packed {
        logic io_allowed;
        logic io_fault;
        logic maskable_interrupt_pin_take;
        logic step_trap;
        logic dbg_suppress;
        logic align_fault_en;
        logic legacy_mode;
        logic str_decrement;
        logic paging_on;
        logic prot_mode;
    } csr_ctl_t;

endpackage

// [rtl/csr_regs.sv]
/*
 * core status and control registers: status flag register, instruction
 * pointer, fault address, page directory base and mode control registers,
 * with the privilege checks and policy outputs they steer.
 * assumes execute-stage retire info arrives on clk_i, the interrupt pin is
 * asynchronous, and software uses the plain register port.
 */
// The strobed register port and the register offsets were chosen for this implementation.
// Function
// - carry flag bit 0 set on carry out of / borrow into top bit
// - parity flag bit 2 set when low 8 result bits hold even ones
// - auxiliary carry bit 4 set on carry or borrow at bit 3
// - zero flag bit 6 set when result is zero
// - sign flag bit 7 copies result top bit
// - trap flag bit 8 traps after next instruction, trap clears it
// - maskable interrupt serviced only while enable flag bit 9 set
// - direction flag bit 10 picks string increment or decrement
// - overflow flag bit 11 is carry-in xor carry-out of sign bit
// - protected io runs unfaulted only when privilege within io field
// - popped flags change interrupt enable only when privilege within io field
// - nested task flag bit 14 marks nested task in protected mode
// - resume flag bit 16 suppresses debug fault on next instruction
// - legacy emulation bit 17 gives legacy segments, faults privileged opcodes, in protected mode only
// - bit 17 set only by interrupt return at level 0, task switch or a register port write
// - alignment check bit 18 enables misaligned access faults
// - instruction pointer advances per instruction unless loaded by transfer
// - low 16 flag bits accessible alone as legacy flag word
// - page fault with paging on captures 32-bit linear fault address
// - page directory base is 4 KByte aligned, low 12 bits zero
// - protected mode control register writes accepted only from level 0
// - alignment faults only while mode mask bit 18 is one
module csr_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // execute stage
    input wire csr_pkg::csr_retire_t ret_i,
    input wire logic [1:0] cpl_i,
    input wire logic io_req_i,
    input wire logic page_fault_i,
    input wire logic [31:0] fault_lin_i,
    input wire logic step_taken_i,
    // interrupt pin
    input wire logic maskable_interrupt_pin_i,
    // state and policy
    output logic [31:0] status_flag_register_o,
    output logic [31:0] instruction_pointer_o,
    output csr_pkg::csr_ctl_t ctl_o,
    output logic priv_err_o
);
`include "csr_cfg.svh"

    // reset release synchroniser
    logic rst_s1_r, rst_b_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_b_r <= rst_s1_r;
        end
    end

    // interrupt pin synchroniser
    logic int_s1_r, int_s2_r;
    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            int_s1_r <= 1'b0;
            int_s2_r <= 1'b0;
        end else begin
            int_s1_r <= maskable_interrupt_pin_i;
            int_s2_r <= int_s1_r;
        end
    end

    // even parity of a byte
    function automatic logic even_par(input logic [7:0] v);
        even_par = ~(^v);
    endfunction

    // privilege check against the io field
    function automatic logic priv_ok(input logic [1:0] current_privilege_level, input logic [1:0] io_privilege_level);
        priv_ok = (current_privilege_level <= io_privilege_level);
    endfunction

    logic [31:0] flags_r, flags_nxt;
    logic [31:0] ip_r, ip_nxt;
    logic [31:0] faddr_r, pdbr_r, mode_r;
    logic [31:0] rdata_r;
    logic perr_r;
    csr_pkg::csr_ctl_t ctl_r, ctl_nxt;

    // control state decode
    wire [1:0] io_privilege_level_w = flags_r[`CSR_B_IO_PRIVILEGE_LEVEL_HI:`CSR_B_IO_PRIVILEGE_LEVEL_LO];
    wire prot_w = mode_r[`CSR_B_PE];
    wire paging_w = prot_w & mode_r[`CSR_B_PG];
    wire io_ok_w = ~prot_w | priv_ok(cpl_i, io_privilege_level_w);
    wire if_ok_w = priv_ok(cpl_i, io_privilege_level_w);
    wire cr_wr_ok_w = ~prot_w | (cpl_i == 2'h0);

    // adder-derived result flags
    wire [32:0] sum_w = ret_i.sub ? ({1'b0, ret_i.opa} - {1'b0, ret_i.opb})
                                  : ({1'b0, ret_i.opa} + {1'b0, ret_i.opb});
    wire [31:0] cin_w = ret_i.opa ^ ret_i.opb ^ ret_i.res;
    wire cf_w = sum_w[32];
    wire af_w = cin_w[4];
    wire of_w = cin_w[31] ^ sum_w[32];
    wire pf_w = even_par(ret_i.res[7:0]);
    wire zf_w = (ret_i.res == 32'h0000_0000);
    wire sf_w = ret_i.res[31];

    // register port decode
    wire wr_flags_w = wr_i & (addr_i == `CSR_OFF_FLAGS);
    wire wr_cr_w = wr_i & cr_wr_ok_w;
    wire cr_sel_w = (addr_i == `CSR_OFF_FADDR) | (addr_i == `CSR_OFF_PDBR)
                  | (addr_i == `CSR_OFF_MODE);
    wire perr_w = wr_i & cr_sel_w & ~cr_wr_ok_w;

    // popped flag value, interrupt enable and bit 17 guarded
    logic [31:0] pop_w;
    always_comb begin
        pop_w = ret_i.pop_16 ? {flags_r[31:16], ret_i.pop_val[15:0]} : ret_i.pop_val;
        if (!if_ok_w)
            pop_w[`CSR_B_IF] = flags_r[`CSR_B_IF];
        if (!((ret_i.iret && cpl_i == 2'h0) || ret_i.task_sw))
            pop_w[`CSR_B_VM] = flags_r[`CSR_B_VM] & pop_w[`CSR_B_VM];
    end

    // next flag value
    always_comb begin
        flags_nxt = flags_r;
        if (ret_i.valid) begin
            if (ret_i.fupd.arith || ret_i.fupd.logic_op) begin
                flags_nxt[`CSR_B_PF] = pf_w;
                flags_nxt[`CSR_B_ZF] = zf_w;
                flags_nxt[`CSR_B_SF] = sf_w;
            end
            if (ret_i.fupd.arith) begin
                flags_nxt[`CSR_B_AF] = af_w;
                flags_nxt[`CSR_B_OF] = of_w;
                if (!ret_i.fupd.keep_cf)
                    flags_nxt[`CSR_B_CF] = cf_w;
            end else if (ret_i.fupd.logic_op) begin
                flags_nxt[`CSR_B_CF] = 1'b0;
                flags_nxt[`CSR_B_OF] = 1'b0;
            end
            if (ret_i.popf || ret_i.iret || ret_i.task_sw)
                flags_nxt = (pop_w & `CSR_FLAGS_WMASK) | `CSR_FLAGS_FIXED1;
            flags_nxt[`CSR_B_RF] = 1'b0;
        end
        if (step_taken_i)
            flags_nxt[`CSR_B_TF] = 1'b0;
        if (wr_flags_w)
            flags_nxt = (wdata_i & `CSR_FLAGS_WMASK) | `CSR_FLAGS_FIXED1;
    end

    // next instruction pointer
    always_comb begin
        ip_nxt = ip_r;
        if (ret_i.valid)
            ip_nxt = ret_i.jump ? ret_i.jump_ip : ret_i.next_ip;
        if (wr_i && addr_i == `CSR_OFF_IPTR)
            ip_nxt = wdata_i;
    end

    // policy outputs
    always_comb begin
        ctl_nxt.io_allowed = io_ok_w;
        ctl_nxt.io_fault = io_req_i & ~io_ok_w;
        ctl_nxt.maskable_interrupt_pin_take = int_s2_r & flags_nxt[`CSR_B_IF];
        ctl_nxt.step_trap = ret_i.valid & flags_r[`CSR_B_TF];
        ctl_nxt.dbg_suppress = flags_nxt[`CSR_B_RF];
        ctl_nxt.align_fault_en = flags_nxt[`CSR_B_AC] & mode_r[`CSR_B_AM];
        ctl_nxt.legacy_mode = prot_w & flags_nxt[`CSR_B_VM];
        ctl_nxt.str_decrement = flags_nxt[`CSR_B_DF];
        ctl_nxt.paging_on = paging_w;
        ctl_nxt.prot_mode = prot_w;
    end

    // read mux
    logic [31:0] rmux_w;
    always_comb begin
        unique case (addr_i)
            `CSR_OFF_FLAGS: rmux_w = flags_r;
            `CSR_OFF_IPTR: rmux_w = ip_r;
            `CSR_OFF_FADDR: rmux_w = faddr_r;
            `CSR_OFF_PDBR: rmux_w = pdbr_r;
            `CSR_OFF_MODE: rmux_w = mode_r;
            `CSR_OFF_CTX: rmux_w = {16'h0000, flags_r[15:0]};
            `CSR_OFF_STAT: rmux_w = {28'h0000000, ctl_r.legacy_mode, perr_r, cpl_i};
            default: rmux_w = 32'h0000_0000;
        endcase
    end

    // flags, pointer, outputs
    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            flags_r <= `CSR_RST_FLAGS;
            ip_r <= `CSR_RST_IPTR;
            ctl_r <= '0;
            rdata_r <= `CSR_RST_ZERO;
            perr_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            ip_r <= ip_nxt;
            ctl_r <= ctl_nxt;
            rdata_r <= rd_i ? rmux_w : `CSR_RST_ZERO;
            perr_r <= perr_w;
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge rst_b_r) begin
        if (!rst_b_r) begin
            faddr_r <= `CSR_RST_ZERO;
            pdbr_r <= `CSR_RST_ZERO;
            mode_r <= `CSR_RST_MODE;
        end else begin
            if (page_fault_i && paging_w)
                faddr_r <= fault_lin_i;
            else if (wr_cr_w && addr_i == `CSR_OFF_FADDR)
                faddr_r <= wdata_i;
            if (wr_cr_w && addr_i == `CSR_OFF_PDBR)
                pdbr_r <= wdata_i & `CSR_PDBR_MASK;
            if (wr_cr_w && addr_i == `CSR_OFF_MODE)
                mode_r <= wdata_i;
        end
    end

    assign rdata_o = rdata_r;
    assign status_flag_register_o = flags_r;
    assign instruction_pointer_o = ip_r;
    assign ctl_o = ctl_r;
    assign priv_err_o = perr_r;

endmodule // csr_regs

// [verification/csr_regs_properties.sv]
/* port assertions for the status and control register block.
   assumes one clock and the active-low reset of the block. */
`include "csr_cfg.svh"
module csr_regs_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // execute side
    input wire csr_pkg::csr_retire_t ret_i,
    input wire logic [1:0] cpl_i,
    input wire logic step_taken_i,
    // state and policy
    input wire logic [31:0] status_flag_register_o,
    input wire logic [31:0] instruction_pointer_o,
    input wire csr_pkg::csr_ctl_t ctl_o,
    input wire logic priv_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [31:0] f;
    logic upd;
    // retire that defines result flags, no write beside it
    assign f = status_flag_register_o;
    assign upd = ret_i.valid && (ret_i.fupd.arith || ret_i.fupd.logic_op) && !wr_i
        && !ret_i.popf && !ret_i.iret && !ret_i.task_sw;
    zero_flag_a: assert property (upd |=> f[6] == ($past(ret_i.res) == 32'h0))
        else $error("zero flag wrong");
    sign_flag_a: assert property (upd |=> f[7] == $past(ret_i.res[31]))
        else $error("sign flag wrong");
    parity_flag_a: assert property (upd |=> f[2] == ~^$past(ret_i.res[7:0]))
        else $error("parity flag wrong");
    logic_clear_a: assert property (upd && !ret_i.fupd.arith |=> !f[0] && !f[11])
        else $error("logic op left carry or overflow");
    ip_advance_a: assert property (ret_i.valid && !wr_i |=> instruction_pointer_o ==
        ($past(ret_i.jump) ? $past(ret_i.jump_ip) : $past(ret_i.next_ip)))
        else $error("pointer update wrong");
    maskable_interrupt_pin_gate_a: assert property (ctl_o.maskable_interrupt_pin_take |-> f[`CSR_B_IF])
        else $error("interrupt taken while disabled");
    priv_refuse_a: assert property (priv_err_o |-> $past(wr_i) && $past(cpl_i) != 2'h0)
        else $error("refusal without unprivileged write");
    pdbr_align_a: assert property ($past(rd_i) && $past(addr_i) == `CSR_OFF_PDBR
        |-> rdata_o[11:0] == 12'h0)
        else $error("directory base low bits set");
    legacy_word_a: assert property ($past(rd_i) && $past(addr_i) == `CSR_OFF_CTX
        |-> rdata_o[15:0] == $past(f[15:0]))
        else $error("legacy flag word wrong");
    step_clear_a: assert property (step_taken_i && !wr_i && !ret_i.valid |=> !f[8])
        else $error("trap flag not cleared");
endmodule // csr_regs_properties
bind csr_regs csr_regs_properties u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ret_i(ret_i), .cpl_i(cpl_i),
    .step_taken_i(step_taken_i), .status_flag_register_o(status_flag_register_o),
    .instruction_pointer_o(instruction_pointer_o), .ctl_o(ctl_o), .priv_err_o(priv_err_o));

// [verification/tb_csr_regs.sv]
/* self-checking bench for the status and control register block.
   assumes csr_regs on a 10 MHz clock behind the plain register port. */
`include "csr_cfg.svh"
module tb_csr_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_b_i, wr_i, rd_i, rd_d, pf_i, st_i, pin_i, perr_o, io_i;
    int n_perr = 0;
    logic [3:0] addr_i;
    logic [31:0] wdata_i, rdata_o, flags_o, ip_o, fa_i, a, b, x, e;
    logic [1:0] cpl_i;
    logic [31:0] q_e[$], q_m[$];
    csr_pkg::csr_retire_t ret_i, r;
    csr_pkg::csr_ctl_t ctl_o;
    int n_errors = 0, n_checks = 0;
    csr_regs uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ret_i(ret_i), .cpl_i(cpl_i),
        .io_req_i(io_i), .page_fault_i(pf_i), .fault_lin_i(fa_i), .step_taken_i(st_i),
        .maskable_interrupt_pin_i(pin_i), .status_flag_register_o(flags_o),
        .instruction_pointer_o(ip_o), .ctl_o(ctl_o), .priv_err_o(perr_o));
    // compare and count
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one-cycle register strobes, reads note their expectation
    task wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= ad;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] ad, input logic [31:0] ex, input logic [31:0] m);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= ad;
        q_e.push_back(ex & m);
        q_m.push_back(m);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // one retiring instruction built in r
    task ret(input logic [31:0] res);
        r.valid = 1'b1;
        r.res = res;
        @(posedge clk_i);
        ret_i <= r;
        @(posedge clk_i);
        ret_i <= '0;
        r = '0;
    endtask
    task pulse_wait(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // result flags from operands
    function automatic logic [31:0] arf(input logic [31:0] p, q, input logic s);
        logic [32:0] t;
        t = s ? {1'b0, p} - {1'b0, q} : {1'b0, p} + {1'b0, q};
        arf = 32'h0;
        arf[0] = t[32];
        arf[2] = ~^t[7:0];
        arf[4] = p[4] ^ q[4] ^ t[4];
        arf[6] = t[31:0] == 32'h0;
        arf[7] = t[31];
        arf[11] = (s ? p[31] != q[31] : p[31] == q[31]) && t[31] != p[31];
    endfunction
    // read data monitor, one cycle after each read strobe
    always @(posedge clk_i) rd_d <= rd_i;
    // count refusal pulses seen on the privilege error output
    always @(posedge clk_i) if (perr_o === 1'b1) n_perr++;
    always @(negedge clk_i) begin
        if (rd_d) begin
            e = q_e.pop_front();
            chk("rdata", rdata_o & q_m.pop_front(), e);
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // watchdog
    initial begin
        #1000000;
        n_errors++;
        results();
    end
    initial begin
        {rst_b_i, wr_i, rd_i, pf_i, st_i, pin_i, io_i, addr_i, wdata_i, fa_i, cpl_i} = '0;
        ret_i = '0;
        r = '0;
        void'($urandom(84));
        pulse_wait(12);
        rst_b_i <= 1'b1;
        pulse_wait(3);
        rd(`CSR_OFF_FLAGS, `CSR_RST_FLAGS, '1);
        rd(`CSR_OFF_MODE, `CSR_RST_MODE, '1);
        rd(4'hF, 32'h0, '1);
        for (int i = 0; i < 12; i++) begin
            a = i == 0 ? 32'h1 : i == 2 ? 32'h7FFF_FFFF : $urandom;
            b = i == 0 ? 32'hFFFF_FFFF : i == 2 ? 32'h1 : $urandom;
            r.sub = i[0];
            r.opa = a;
            r.opb = b;
            r.fupd.arith = 1'b1;
            e = arf(a, b, r.sub);
            x = e;
            ret(r.sub ? a - b : a + b);
            rd(`CSR_OFF_FLAGS, x, 32'h8D5);
        end
        r.fupd.logic_op = 1'b1;
        ret(32'h80);
        rd(`CSR_OFF_FLAGS, x & 32'h10, 32'h8D5);
        a = $urandom;
        r.next_ip = a;
        ret(32'h0);
        rd(`CSR_OFF_FLAGS, x & 32'h10, 32'h8D5);
        rd(`CSR_OFF_IPTR, a, '1);
        r.jump = 1'b1;
        r.jump_ip = ~a;
        ret(32'h0);
        rd(`CSR_OFF_IPTR, ~a, '1);
        wr(`CSR_OFF_FLAGS, '1);
        pin_i <= 1'b1;
        rd(`CSR_OFF_FLAGS, `CSR_FLAGS_WMASK | `CSR_FLAGS_FIXED1, '1);
        rd(`CSR_OFF_CTX, `CSR_FLAGS_WMASK | `CSR_FLAGS_FIXED1, 32'hFFFF);
        pulse_wait(4);
        chk("maskable_interrupt_pin", ctl_o.maskable_interrupt_pin_take, 1);
        chk("decrement", ctl_o.str_decrement, 1);
        chk("align", ctl_o.align_fault_en, 0);
        st_i <= 1'b1;
        pulse_wait(1);
        st_i <= 1'b0;
        rd(`CSR_OFF_FLAGS, 32'h0, 32'h100);
        wr(`CSR_OFF_MODE, 32'h8004_0011);
        wr(`CSR_OFF_FLAGS, 32'h0004_0000);
        pulse_wait(4);
        chk("maskable_interrupt_pin", ctl_o.maskable_interrupt_pin_take, 0);
        chk("decrement", ctl_o.str_decrement, 0);
        chk("align", ctl_o.align_fault_en, 1);
        fa_i <= a;
        pf_i <= 1'b1;
        pulse_wait(1);
        pf_i <= 1'b0;
        rd(`CSR_OFF_FADDR, a, '1);
        wr(`CSR_OFF_PDBR, '1);
        rd(`CSR_OFF_PDBR, `CSR_PDBR_MASK, '1);
        cpl_i <= 2'h3;
        wr(`CSR_OFF_PDBR, 32'h0);
        rd(`CSR_OFF_PDBR, `CSR_PDBR_MASK, '1);
        rd(`CSR_OFF_MODE, 32'h8004_0011, 32'h8004_0011);
        chk("perr", n_perr, 1);
        io_i <= 1'b1;
        pulse_wait(3);
        chk("io fault", ctl_o.io_fault, 1);
        chk("io allowed", ctl_o.io_allowed, 0);
        chk("legacy", ctl_o.legacy_mode, 0);
        r.popf = 1'b1;
        r.pop_val = '1;
        ret(32'h0);
        rd(`CSR_OFF_FLAGS, 32'h400, 32'h20600);
        cpl_i <= 2'h0;
        r.iret = 1'b1;
        r.pop_val = '1;
        ret(32'h0);
        rd(`CSR_OFF_FLAGS, 32'h20200, 32'h20200);
        pulse_wait(3);
        chk("io fault", ctl_o.io_fault, 0);
        chk("io allowed", ctl_o.io_allowed, 1);
        chk("legacy", ctl_o.legacy_mode, 1);
        chk("paging", ctl_o.paging_on, 1);
        results();
    end
endmodule // tb_csr_regs
